// [hdl/tscr_map.vh]
// Register offsets, field positions and reset values of the transceiver status/control bank
`ifndef TSCR_MAP_VH
`define TSCR_MAP_VH

// Register offsets (byte-wide registers at printed offsets)
`define TSCR_OFF_IRQ_MASK 4'h0
`define TSCR_OFF_IRQ_STAT 4'h1
`define TSCR_OFF_ALARM 4'h2
`define TSCR_OFF_CLK_CTRL 4'h3

// Source bit positions in mask, status and alarm registers (alarm register holds bits 0 to 3 only)
`define TSCR_BIT_OVERFLOW 0
`define TSCR_BIT_MULT_LOCK 1
`define TSCR_BIT_REC_LOCK 2
`define TSCR_BIT_SIG_LOSS 3
`define TSCR_BIT_OSC_LOCK 4
`define TSCR_SRC_MASK 8'h1f
`define TSCR_ALARM_MASK 8'h0f

// Clocking control field positions
`define TSCR_CTL_MANUAL_FLUSH 0
`define TSCR_CTL_AUTO_FLUSH 1
`define TSCR_CTL_AUX_HIZ 2
`define TSCR_CTL_DEJITTER 3
`define TSCR_CTL_BANDWIDTH 4
`define TSCR_CTL_SEC_SOURCE 5
`define TSCR_CTL_REF_RATE 6
`define TSCR_CTL_SEC_OFF 7

// Reset values
`define TSCR_RST_CTRL 8'h00
`define TSCR_RST_MASK 8'h00
`define TSCR_RST_STAT 8'h00

`endif

// [hdl/tscr_change_det.v]
// Change detector that raises one pulse per source whose level toggled
`timescale 1ns/100ps
`default_nettype none

module tscr_change_det #(
  parameter WIDTH = 5
) (
  input wire sys_clk, // System clock
  input wire rstn, // Asynchronous reset, active low
  input wire [WIDTH-1:0] level_in, // Live source levels
  output wire [WIDTH-1:0] change_pulse // One-cycle pulse per changed source
);

  reg [WIDTH-1:0] prev_q;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= {WIDTH{1'b0}};
    end else begin
      prev_q <= level_in;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_chg
      assign change_pulse[i] = level_in[i] ^ prev_q[i];
    end
  endgenerate

endmodule

`default_nettype wire

// [hdl/tscr_regs.v]
// Status and control register bank of a serial transceiver channel
`timescale 1ns/100ps
`default_nettype none
`include "tscr_map.vh"

module tscr_regs #(
  parameter ADDR_W = 4
) (
  input wire sys_clk, // System clock, 10 MHz
  input wire rstn, // Asynchronous reset, active low
  input wire [ADDR_W-1:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [7:0] reg_rdata, // Read data, valid cycle after strobe
  input wire signal_loss_flag, // Loss of signal present
  input wire recovery_lock_flag, // Recovery loop lock indication
  input wire multiplier_lock_flag, // Multiplier loop lock indication
  input wire overflow_alarm_flag, // Transmit FIFO overflow indication
  input wire osc_lock_flag, // External oscillator lock indication
  output wire secondary_output_off, // Disable secondary serial output
  output wire reference_rate_choice, // High reference frequency selected
  output wire secondary_output_source, // Clock instead of data on secondary
  output wire multiplier_bandwidth, // Wide multiplier loop bandwidth
  output wire dejitter_reference_choice, // De-jitter oscillator as reference
  output wire aux_clock_hiz, // Auxiliary clock output high impedance
  output wire aux_clock_oe_n, // Auxiliary clock output enable, low drives
  output wire overflow_auto_flush, // Automatic flush on overflow enabled
  output wire buffer_manual_flush, // Manual flush control bit
  output reg fifo_flush, // FIFO flush command to datapath
  output wire irq // Level interrupt, high while unmasked status set
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function hit;
    input [ADDR_W-1:0] a;
    input [3:0] off;
    reg [ADDR_W+3:0] ext;
    begin
      ext = {{ADDR_W{1'b0}}, off};
      hit = (a == ext[ADDR_W-1:0]);
    end
  endfunction

  wire wr_mask = reg_wr & hit(reg_addr, `TSCR_OFF_IRQ_MASK);
  wire wr_ctrl = reg_wr & hit(reg_addr, `TSCR_OFF_CLK_CTRL);
  wire rd_stat = reg_rd & hit(reg_addr, `TSCR_OFF_IRQ_STAT);

  // ----------------------------------------------------------------
  // Live alarm state
  // ----------------------------------------------------------------
  wire [4:0] src_level;
  assign src_level[`TSCR_BIT_OVERFLOW] = overflow_alarm_flag;
  assign src_level[`TSCR_BIT_MULT_LOCK] = multiplier_lock_flag;
  assign src_level[`TSCR_BIT_REC_LOCK] = recovery_lock_flag;
  assign src_level[`TSCR_BIT_SIG_LOSS] = signal_loss_flag;
  assign src_level[`TSCR_BIT_OSC_LOCK] = osc_lock_flag;

  wire [4:0] src_change;

  tscr_change_det #(
    .WIDTH(5)
  ) u_chg (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .level_in(src_level),
    .change_pulse(src_change)
  );

  // ----------------------------------------------------------------
  // Control, mask and sticky status
  // ----------------------------------------------------------------
  reg [7:0] ctrl_q;
  reg [4:0] mask_q;
  reg [4:0] stat_q;
  reg [4:0] stat_d;

  always @* begin
    stat_d = stat_q;
    if (rd_stat) begin
      stat_d = 5'h00;
    end
    stat_d = stat_d | src_change;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `TSCR_RST_CTRL;
      mask_q <= 5'h00;
      stat_q <= 5'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[4:0];
      end
      stat_q <= stat_d;
    end
  end

  // Interrupt only for enabled sources
  assign irq = |(stat_q & mask_q);

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign secondary_output_off = ctrl_q[`TSCR_CTL_SEC_OFF];
  assign reference_rate_choice = ctrl_q[`TSCR_CTL_REF_RATE];
  assign secondary_output_source = ctrl_q[`TSCR_CTL_SEC_SOURCE];
  assign multiplier_bandwidth = ctrl_q[`TSCR_CTL_BANDWIDTH];
  assign dejitter_reference_choice = ctrl_q[`TSCR_CTL_DEJITTER];
  assign aux_clock_hiz = ctrl_q[`TSCR_CTL_AUX_HIZ];
  assign aux_clock_oe_n = ctrl_q[`TSCR_CTL_AUX_HIZ];
  assign overflow_auto_flush = ctrl_q[`TSCR_CTL_AUTO_FLUSH];
  assign buffer_manual_flush = ctrl_q[`TSCR_CTL_MANUAL_FLUSH];

  // ----------------------------------------------------------------
  // FIFO flush: held by manual bit, one pulse per overflow in auto mode
  // ----------------------------------------------------------------
  wire ovf_rise = src_change[`TSCR_BIT_OVERFLOW] & overflow_alarm_flag;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fifo_flush <= 1'b0;
    end else begin
      fifo_flush <= buffer_manual_flush | (overflow_auto_flush & ovf_rise);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, `TSCR_OFF_IRQ_MASK)) begin
        reg_rdata <= {3'h0, mask_q};
      end else if (hit(reg_addr, `TSCR_OFF_IRQ_STAT)) begin
        reg_rdata <= {3'h0, stat_q};
      end else if (hit(reg_addr, `TSCR_OFF_ALARM)) begin
        reg_rdata <= {4'h0, src_level[3:0]};
      end else if (hit(reg_addr, `TSCR_OFF_CLK_CTRL)) begin
        reg_rdata <= ctrl_q;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// [sim/tscr_regs_properties.sv]
// Port assertions of the status and control bank
`timescale 1ns/100ps
`default_nettype none
module tscr_regs_properties #(parameter ADDR_W = 4) (
  input wire logic sys_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic [ADDR_W-1:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Wdata
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_rdata, // Rdata
  input wire logic signal_loss_flag, // Loss
  input wire logic overflow_alarm_flag, // Overflow
  input wire logic aux_clock_hiz, // Hiz
  input wire logic aux_clock_oe_n, // Enable
  input wire logic overflow_auto_flush, // Auto
  input wire logic buffer_manual_flush, // Manual
  input wire logic fifo_flush, // Flush
  input wire logic irq // Irq
);
  wire [2:0] lo = reg_wdata[2:0];
  wire [2:0] ctl3 = {aux_clock_hiz, overflow_auto_flush, buffer_manual_flush};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_LOSS_READ: assert property (reg_rd && reg_addr == 4'h2 |=>
    reg_rdata[7:3] == {4'h0, $past(signal_loss_flag)}) else $error("Loss bit misread");
  AST_CTL_WRITE: assert property (reg_wr && reg_addr == 4'h3 |=>
    ctl3 == $past(lo)) else $error("Control write lost");
  AST_CTL_HOLD: assert property (!(reg_wr && reg_addr == 4'h3) |=>
    $stable(ctl3)) else $error("Control changed unasked");
  AST_OE: assert property (aux_clock_oe_n == aux_clock_hiz)
    else $error("Aux enable wrong");
  AST_MAN_FLUSH: assert property (buffer_manual_flush |=> fifo_flush)
    else $error("Manual flush missing");
  AST_AUTO_FLUSH: assert property (overflow_auto_flush && $rose(overflow_alarm_flag)
    |=> fifo_flush) else $error("Auto flush missing");
  AST_NO_FLUSH: assert property (!buffer_manual_flush && !overflow_auto_flush
    |=> !fifo_flush) else $error("Flush without cause");
  AST_IRQ_OFF: assert property (reg_wr && reg_addr == 4'h0 && lo == 3'h0 &&
    reg_wdata[4:3] == 2'h0 |=> !irq) else $error("Masked irq high");
  cover property (irq);
  cover property (fifo_flush && !buffer_manual_flush);
  cover property (reg_rd && reg_addr == 4'h1 ##1 reg_rdata != 8'h00);
endmodule
bind tscr_regs tscr_regs_properties #(.ADDR_W(ADDR_W)) u_props (.sys_clk(sys_clk),
  .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .irq(irq),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .signal_loss_flag(signal_loss_flag),
  .overflow_alarm_flag(overflow_alarm_flag), .aux_clock_hiz(aux_clock_hiz),
  .aux_clock_oe_n(aux_clock_oe_n), .overflow_auto_flush(overflow_auto_flush),
  .buffer_manual_flush(buffer_manual_flush), .fifo_flush(fifo_flush));
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the status and control bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] adr = 4'h0;
  logic wr = 1'b0, rd = 1'b0, ef = 1'b0;
  logic [4:0] fl = 5'h00, pv = 5'h00, ch;
  logic [7:0] wd = 8'h00, mk = 8'h00, st = 8'h00, ct = 8'h00, er = 8'h00;
  wire [7:0] rdat, co;
  wire oen, ff, irq;
  int n_fail = 0;
  int total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  tscr_regs u_tscr_regs (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(adr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .signal_loss_flag(fl[3]),
    .recovery_lock_flag(fl[2]), .multiplier_lock_flag(fl[1]), .overflow_alarm_flag(fl[0]),
    .osc_lock_flag(fl[4]), .secondary_output_off(co[7]), .reference_rate_choice(co[6]),
    .secondary_output_source(co[5]), .multiplier_bandwidth(co[4]), .irq(irq),
    .dejitter_reference_choice(co[3]), .aux_clock_hiz(co[2]), .aux_clock_oe_n(oen),
    .overflow_auto_flush(co[1]), .buffer_manual_flush(co[0]), .fifo_flush(ff));
  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    int op;
    bit pw;
    void'($urandom(32'ha6ea03b9));
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (rstn) begin
        ch = fl ^ pv;
        ef = ct[0] | (ct[1] & ch[0] & fl[0]);
        er = !rd ? 8'h00 : adr == 4'h0 ? mk : adr == 4'h1 ? st :
          adr == 4'h2 ? {4'h0, fl[3:0]} : adr == 4'h3 ? ct : 8'h00;
        st = ((rd && adr == 4'h1) ? 8'h00 : st) | {3'h0, ch};
        if (wr && adr == 4'h0) mk = wd & 8'h1f;
        if (wr && adr == 4'h3) ct = wd;
        pv = fl;
      end
      // Random traffic, unmapped address 4, reset again mid-run
      // Power-up flush: manual bit written, then held ten cycles
      pw = (i >= 5 && i < 16);
      op = pw ? ((i == 5) ? 1 : 0) : $urandom % 3;
      rstn <= !(i < 4 || (i >= 1500 && i < 1504));
      adr <= pw ? 4'h3 : 4'($urandom % 5);
      wd <= pw ? 8'h01 : 8'($urandom);
      wr <= (op == 1);
      rd <= (op == 2);
      if ($urandom % 4 == 0) fl <= fl ^ (5'h01 << ($urandom % 5));
      #1;
      if (!rstn) begin
        {mk, st, ct, er, pv} = '0;
        ef = 1'b0;
      end
      `CHK("rdata", er, rdat)
      `CHK("ctrl", ct, co)
      `CHK("oe_n", ct[2], oen)
      `CHK("flush", ef, ff)
      `CHK("irq", |(st & mk), irq)
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
